// File: design/wdt_params.svh
// constants of the runaway guard timer: offsets, field positions, resets, keys
// assumes inclusion by bare name from the package and the design modules
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_ADDR_W 24
`define WDT_OFS_CTRL_RELOAD 24'h14_0000
`define WDT_OFS_COUNT_SERVICE 24'h14_0004

`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_FREEZE_BIT 1
`define WDT_CTRL_LIGHT_BIT 2
`define WDT_CTRL_IDLE_BIT 3
`define WDT_CTRL_BITS 4
`define WDT_CTRL_LSB 16

`define WDT_CTRL_RESET 16'h000C
`define WDT_RELOAD_RESET 16'hFFFF
`define WDT_KEY_ARM 16'h5555
`define WDT_KEY_FIRE 16'hAAAA

`define WDT_PRESCALE_DIV 8192

`endif

// File: design/wdt_pkg.sv
// types shared by the runaway guard timer design
// assumes wdt_params.svh on the include path
`include "wdt_params.svh"

package wdt_pkg;

    typedef struct packed {
        logic [`WDT_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic [3:0] byte_en;
        logic wr;
        logic rd;
        logic supervisor;
    } bus_req_t;

    typedef struct packed {
        logic wait_mode;
        logic doze_mode;
        logic stop_mode;
        logic core_halted;
    } power_state_t;

    typedef enum logic {
        SVC_IDLE,
        SVC_ARMED
    } service_state_t;

endpackage

// File: design/wdt_prescaler.sv
// clock divider ahead of the watchdog counter
// assumes one system clock and an active-high asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module wdt_prescaler #(
    parameter int DIV = 8192
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic i_clear,
    output logic o_tick
);

    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_q;

    // cleared on every counter load, frozen while not running
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_q <= '0;
        end else if (i_clear) begin
            cnt_q <= '0;
        end else if (i_run) begin
            if (cnt_q == LAST) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= i_run && !i_clear && (cnt_q == LAST);
        end
    end

endmodule // wdt_prescaler

`default_nettype wire

// File: design/runaway_guard_timer.sv
// runaway guard timer: 16-bit watchdog with register port and reset request
// assumes synchronous power-mode inputs and a reset controller on o_reset_req
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"

// Behaviour
// - 16-bit down-counter runs while enabled; underflow raises reset request.
// - in wait mode, counter freezes when sleep_idle_stop is set.
// - in doze mode, counter freezes when light_sleep_stop is set.
// - stop mode halts counting; exit resumes from the held state.
// - halted with debug_freeze_stop set stops counting; halt-time writes persist.
// - with debug_freeze_stop clear at halt entry, counter keeps running while halted.
// - control/reload in word 0x14_0000; count/service in word 0x14_0004.
// - control/reload supervisor only; user access ignored with transfer error.
// - control bits: enable 0, freeze 1, light 2, idle 3; rest reserved.
// - control bits lock after first write, except writes while halted.
// - reset sets sleep_idle_stop and light_sleep_stop.
// - registers writable while halted; first write while halted leaves unlocked.
// - clearing debug_freeze_stop while halted stops the counter.
// - enable clear holds counter and prescaler; enable set runs.
// - service is 0x5555 then 0xAAAA; other values restart the sequence.
// - timeout without service signals the reset controller.
// - reload write loads counter at once, clears prescaler; resets to 0xFFFF.
// - count reads live value; writes to it ignored, normal end.
module runaway_guard_timer #(
    parameter int PRESCALE_DIV = `WDT_PRESCALE_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire wdt_pkg::bus_req_t i_bus,
    input wire wdt_pkg::power_state_t i_power,
    output logic [31:0] o_rdata,
    output logic o_xfer_err,
    output logic o_reset_req
);

    ////////////////////////////////////////////////////////////////////////////
    // constants

    localparam logic [15:0] CTRL_RST = `WDT_CTRL_RESET;
    localparam logic [15:0] RELOAD_RST = `WDT_RELOAD_RESET;
    localparam logic [15:0] KEY_ARM = `WDT_KEY_ARM;
    localparam logic [15:0] KEY_FIRE = `WDT_KEY_FIRE;
    localparam logic [`WDT_ADDR_W-1:0] OFS_W0 = `WDT_OFS_CTRL_RELOAD;
    localparam logic [`WDT_ADDR_W-1:0] OFS_W1 = `WDT_OFS_COUNT_SERVICE;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // word match, ignoring the byte offset inside the word
    function automatic logic word_hit(
        input logic [`WDT_ADDR_W-1:0] addr,
        input logic [`WDT_ADDR_W-1:0] ofs
    );
        word_hit = (addr[`WDT_ADDR_W-1:2] == ofs[`WDT_ADDR_W-1:2]);
    endfunction

    logic hit_w0;
    logic hit_w1;
    logic priv_ok;
    logic halted;
    logic ctrl_we;
    logic reload_we;
    logic svc_we;
    logic user_err;
    logic [15:0] wr_hi;
    logic [15:0] wr_lo;

    always_comb begin
        hit_w0 = word_hit(i_bus.addr, OFS_W0);
        hit_w1 = word_hit(i_bus.addr, OFS_W1);
        priv_ok = i_bus.supervisor;
        halted = i_power.core_halted;
        wr_hi = i_bus.wdata[31:16];
        wr_lo = i_bus.wdata[15:0];
        // upper half of word 0 is control, lower half is reload
        ctrl_we = i_bus.wr && hit_w0 && priv_ok && (|i_bus.byte_en[3:2]);
        reload_we = i_bus.wr && hit_w0 && priv_ok && (|i_bus.byte_en[1:0]);
        // lower half of word 1 is the service key, any privilege
        svc_we = i_bus.wr && hit_w1 && (|i_bus.byte_en[1:0]);
        user_err = (i_bus.wr || i_bus.rd) && hit_w0 && !priv_ok;
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register, one lock per bit

    logic [`WDT_CTRL_BITS-1:0] ctrl_q;
    logic [`WDT_CTRL_BITS-1:0] ctrl_lock_q;
    logic [`WDT_CTRL_BITS-1:0] ctrl_take;

    genvar gi;
    generate
        for (gi = 0; gi < `WDT_CTRL_BITS; gi++) begin : g_ctrl
            assign ctrl_take[gi] = ctrl_we && (!ctrl_lock_q[gi] || halted);

            always_ff @(posedge i_sys_clk or posedge i_reset) begin
                if (i_reset) begin
                    ctrl_q[gi] <= CTRL_RST[gi];
                end else if (ctrl_take[gi]) begin
                    ctrl_q[gi] <= wr_hi[gi];
                end
            end

            // a write made while halted does not lock the bit
            always_ff @(posedge i_sys_clk or posedge i_reset) begin
                if (i_reset) begin
                    ctrl_lock_q[gi] <= 1'b0;
                end else if (ctrl_we && !halted) begin
                    ctrl_lock_q[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    logic en;
    logic freeze_stop;
    logic light_stop;
    logic idle_stop;

    always_comb begin
        en = ctrl_q[`WDT_CTRL_EN_BIT];
        freeze_stop = ctrl_q[`WDT_CTRL_FREEZE_BIT];
        light_stop = ctrl_q[`WDT_CTRL_LIGHT_BIT];
        idle_stop = ctrl_q[`WDT_CTRL_IDLE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // freeze bit dropped during halt

    logic freeze_drop;
    logic freeze_drop_q;

    always_comb begin
        freeze_drop = halted && ctrl_take[`WDT_CTRL_FREEZE_BIT] && freeze_stop
            && !wr_hi[`WDT_CTRL_FREEZE_BIT];
    end

    // held until the halt ends; the set wins over the clear
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            freeze_drop_q <= 1'b0;
        end else if (freeze_drop) begin
            freeze_drop_q <= 1'b1;
        end else if (!halted) begin
            freeze_drop_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reload register

    logic [15:0] reload_q;
    logic reload_lock_q;
    logic reload_take;

    always_comb begin
        reload_take = reload_we && (!reload_lock_q || halted);
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            reload_q <= RELOAD_RST;
        end else if (reload_take) begin
            reload_q <= wr_lo;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            reload_lock_q <= 1'b0;
        end else if (reload_we && !halted) begin
            reload_lock_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // service key sequence

    wdt_pkg::service_state_t svc_state_q;
    logic svc_fire;

    always_comb begin
        svc_fire = svc_we && (svc_state_q == wdt_pkg::SVC_ARMED)
            && (wr_lo == KEY_FIRE);
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            svc_state_q <= wdt_pkg::SVC_IDLE;
        end else if (svc_we) begin
            unique case (svc_state_q)
                wdt_pkg::SVC_IDLE: begin
                    if (wr_lo == KEY_ARM) begin
                        svc_state_q <= wdt_pkg::SVC_ARMED;
                    end
                end
                wdt_pkg::SVC_ARMED: begin
                    // repeated arm key keeps the sequence armed
                    if (wr_lo != KEY_ARM) begin
                        svc_state_q <= wdt_pkg::SVC_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run gating

    logic run;
    logic load_cnt;
    logic [15:0] load_val;

    always_comb begin
        run = en
            && !i_power.stop_mode
            && !(i_power.wait_mode && idle_stop)
            && !(i_power.doze_mode && light_stop)
            && !(halted && (freeze_stop || freeze_drop_q))
            && !o_reset_req;
        load_cnt = reload_take || svc_fire;
        load_val = reload_take ? wr_lo : reload_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler

    logic tick;

    wdt_prescaler #(
        .DIV(PRESCALE_DIV)
    ) u_prescaler (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_run(run),
        .i_clear(load_cnt),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // watchdog counter and reset request

    logic [15:0] count_q;
    logic underflow;

    always_comb begin
        underflow = tick && run && !load_cnt && (count_q == 16'h0000);
    end

    // frozen states simply hold the count, so resume is exact
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            count_q <= RELOAD_RST;
        end else if (load_cnt) begin
            count_q <= load_val;
        end else if (tick && run && (count_q != 16'h0000)) begin
            count_q <= count_q - 16'h0001;
        end
    end

    // stays raised until the system reset arrives
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reset_req <= 1'b0;
        end else if (underflow) begin
            o_reset_req <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path and transfer error

    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_w0 && priv_ok) begin
            rd_word = {12'h000, ctrl_q, reload_q};
        end else if (hit_w1) begin
            rd_word = {count_q, 16'h0000};
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_bus.rd) begin
            o_rdata <= rd_word;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_xfer_err <= 1'b0;
        end else begin
            o_xfer_err <= user_err;
        end
    end

endmodule // runaway_guard_timer

`default_nettype wire

// File: bench/wdt_asserts.sv
// checker: register-port answers and reset request of the guard timer
// assumes binding onto runaway_guard_timer, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"
module wdt_asserts #(
    parameter int PRESCALE_DIV = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire wdt_pkg::bus_req_t i_bus,
    input wire wdt_pkg::power_state_t i_power,
    input wire logic [31:0] o_rdata,
    input wire logic o_xfer_err,
    input wire logic o_reset_req
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    logic w0;
    logic w1;
    int cyc_q;
    assign w0 = {i_bus.addr[23:2], 2'b00} == `WDT_OFS_CTRL_RELOAD;
    assign w1 = {i_bus.addr[23:2], 2'b00} == `WDT_OFS_COUNT_SERVICE;
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cyc_q <= 0;
        end else if (cyc_q < 1000) begin
            cyc_q <= cyc_q + 1;
        end
    end
    sequence s_user0;
        (i_bus.rd || i_bus.wr) && w0 && !i_bus.supervisor;
    endsequence
    a_err_user: assert property (s_user0 |=> o_xfer_err)
        else $error("no transfer error on user access");
    a_err_only: assert property (!(i_bus.rd || i_bus.wr) |=> !o_xfer_err)
        else $error("transfer error without access");
    a_user_zero: assert property (s_user0 ##0 i_bus.rd |=> o_rdata == 32'h0000_0000)
        else $error("user read returned data");
    a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    a_ctrl_rsvd: assert property (i_bus.rd && w0 |=> o_rdata[31:20] == 12'h000)
        else $error("reserved control bits set");
    a_key_zero: assert property (i_bus.rd && w1 |=> o_rdata[15:0] == 16'h0000)
        else $error("service half not zero");
    a_req_held: assert property ($rose(o_reset_req) |=> o_reset_req [*8])
        else $error("reset request dropped");
    a_req_late: assert property ($rose(o_reset_req) |-> cyc_q > PRESCALE_DIV)
        else $error("reset request too early");
endmodule // wdt_asserts
bind runaway_guard_timer wdt_asserts #(.PRESCALE_DIV(PRESCALE_DIV)) chk_u (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_bus(i_bus),
    .i_power(i_power),
    .o_rdata(o_rdata),
    .o_xfer_err(o_xfer_err),
    .o_reset_req(o_reset_req)
);
`default_nettype wire

// File: bench/reset_ctrl_model.sv
// reset controller stand-in: latches the watchdog reset cause
// assumes the request is a level on the system clock
`timescale 1ns/1ps
`default_nettype none
module reset_ctrl_model (
    input wire logic i_sys_clk,
    input wire logic i_por,
    input wire logic i_req,
    output logic o_cause
);
    always_ff @(posedge i_sys_clk or posedge i_por) begin
        if (i_por) begin
            o_cause <= 1'b0;
        end else if (i_req) begin
            o_cause <= 1'b1;
        end
    end
endmodule // reset_ctrl_model
`default_nettype wire

// File: bench/runaway_guard_timer_test.sv
// bench: drives register port and power modes, checks against a model
// assumes design, checker and reset controller model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"
module runaway_guard_timer_test;
    localparam logic [23:0] A0 = `WDT_OFS_CTRL_RELOAD;
    localparam logic [23:0] A1 = `WDT_OFS_COUNT_SERVICE;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    wdt_pkg::bus_req_t bus = '0;
    wdt_pkg::power_state_t pw = '0;
    logic [31:0] o_rdata;
    logic o_xfer_err;
    logic o_reset_req;
    logic cause;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 42714;
    int n;
    int m;
    logic [3:0] ctrl_m = 4'hC;
    logic [15:0] rel_m = 16'hFFFF;
    logic [4:0] lk = '0;
    logic [31:0] d;
    logic e;
    logic [15:0] c1;
    logic [15:0] c2;
    always #12.5 i_sys_clk = ~i_sys_clk;
    runaway_guard_timer #(.PRESCALE_DIV(4)) dut_u (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_bus(bus),
        .i_power(pw),
        .o_rdata(o_rdata),
        .o_xfer_err(o_xfer_err),
        .o_reset_req(o_reset_req)
    );
    reset_ctrl_model rc_u (
        .i_sys_clk(i_sys_clk),
        .i_por(i_reset),
        .i_req(o_reset_req),
        .o_cause(cause)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] exp0();
        return {12'h000, ctrl_m, rel_m};
    endfunction
    task automatic wr(input logic [23:0] a, input logic [31:0] v, input logic [3:0] be,
                      input logic s);
        @(posedge i_sys_clk);
        bus <= '{addr: a, wdata: v, byte_en: be, wr: 1'b1, rd: 1'b0, supervisor: s};
        @(posedge i_sys_clk);
        bus.wr <= 1'b0;
        #1;
        e = o_xfer_err;
        if (a == A0 && s) begin
            // write-once locks, halted writes leave them open
            for (int i = 0; i < 4; i++) begin
                if (be[3:2] != 0 && (!lk[i] || pw.core_halted)) begin
                    ctrl_m[i] = v[16+i];
                    lk[i] = lk[i] | !pw.core_halted;
                end
            end
            if (be[1:0] != 0 && (!lk[4] || pw.core_halted)) begin
                rel_m = v[15:0];
                lk[4] = lk[4] | !pw.core_halted;
            end
        end
    endtask
    task automatic rd(input logic [23:0] a, input logic s);
        @(posedge i_sys_clk);
        bus <= '{addr: a, wdata: 32'h0000_0000, byte_en: 4'h0, wr: 1'b0, rd: 1'b1,
                 supervisor: s};
        @(posedge i_sys_clk);
        bus.rd <= 1'b0;
        #1;
        d = o_rdata;
        e = o_xfer_err;
    endtask
    task automatic rc(output logic [15:0] c);
        rd(A1, 1'b1);
        c = d[31:16];
    endtask
    task automatic span();
        repeat (3) @(posedge i_sys_clk);
        rc(c2);
        repeat (20) @(posedge i_sys_clk);
        rc(c1);
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        n_errors++;
        $display("ERROR %0t: timeout", $time);
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rd(A0, 1'b1); chk(d, exp0());
        rd(A1, 1'b1); chk(d, 32'hFFFF_0000);
        wr(A0, 32'h000F_0000, 4'hF, 1'b0); chk(e, 1);
        rd(A0, 1'b1); chk(d, exp0());
        rd(A1, 1'b0); chk(e, 0);
        done("reset and privilege");
        n = 8 + ($random(seed) & 7);
        m = n + 32;
        pw.core_halted <= 1'b1;
        wr(A0, 32'h0003_0000, 4'hC, 1'b1);
        wr(A0, n, 4'h3, 1'b1);
        rc(c1); chk(c1, n);
        repeat (20) @(posedge i_sys_clk);
        rc(c1); chk(c1, n);
        wr(A0, 32'h0001_0000, 4'hC, 1'b1);
        repeat (20) @(posedge i_sys_clk);
        rc(c1); chk(c1, n);
        rd(A0, 1'b1); chk(d, exp0());
        pw.core_halted <= 1'b0;
        wr(A0, 32'h0009_0000, 4'hC, 1'b1);
        wr(A0, 32'h0000_0000, 4'hC, 1'b1);
        wr(A0, m, 4'h3, 1'b1);
        wr(A0, 32'h0000_0005, 4'h3, 1'b1);
        rd(A0, 1'b1); chk(d, exp0());
        done("halted writes and locks");
        pw.wait_mode <= 1'b1;
        span(); chk(c1, c2);
        wr(A1, 32'h0000_0000, 4'hC, 1'b1); chk(e, 0);
        rc(c1); chk(c1, c2);
        wr(A1, `WDT_KEY_ARM, 4'h3, 1'b0);
        wr(A1, 32'h0000_1234, 4'h3, 1'b0);
        wr(A1, `WDT_KEY_FIRE, 4'h3, 1'b0);
        rc(c1); chk(c1, c2);
        wr(A1, `WDT_KEY_ARM, 4'h3, 1'b0);
        rd(A0, 1'b1);
        wr(A1, `WDT_KEY_FIRE, 4'h3, 1'b0);
        rc(c1); chk(c1, m);
        pw.wait_mode <= 1'b0;
        pw.stop_mode <= 1'b1;
        span(); chk(c1, c2);
        pw.stop_mode <= 1'b0;
        pw.doze_mode <= 1'b1;
        span(); chk(c2 - c1 inside {[5:6]}, 1);
        pw.doze_mode <= 1'b0;
        pw.core_halted <= 1'b1;
        span(); chk(c1 < c2, 1);
        pw.core_halted <= 1'b0;
        done("modes and service");
        for (int k = 0; k < 400 && o_reset_req !== 1'b1; k++) begin
            @(posedge i_sys_clk);
        end
        #1;
        chk(o_reset_req, 1);
        chk(cause, 1);
        rc(c1); chk(c1, 0);
        done("underflow");
        tally_and_finish();
    end
endmodule // runaway_guard_timer_test
`default_nettype wire
